/* shared/apt_pkg.sv */
// package for the angular phase timer: register map, field layout, reset values, types
package apt_pkg;

  localparam int APT_CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] APT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] APT_RES_OFS    = 8'h04;
  localparam logic [7:0] APT_PER_OFS    = 8'h08;
  localparam logic [7:0] APT_PHS_OFS    = 8'h0C;
  localparam logic [7:0] APT_IRQ_OFS    = 8'h10;
  localparam logic [7:0] APT_MASK_OFS   = 8'h14;
  localparam logic [7:0] APT_STAT_OFS   = 8'h18;

  // control register fields
  localparam int APT_CTRL_EN_BIT    = 0;
  localparam int APT_CTRL_MULTI_BIT = 1;

  // interrupt flag fields
  localparam int APT_IRQ_PHS_BIT = 0;
  localparam int APT_IRQ_PER_BIT = 1;
  localparam int APT_IRQ_MISS_BIT = 2;
  localparam int APT_IRQ_W       = 3;

  // reset values
  localparam logic [15:0] APT_RES_RST  = 16'h0000;
  localparam logic [1:0]  APT_CTRL_RST = 2'h0;

  // missing pulse: interval exceeds previous by half again (period_value * 3/2)
  localparam int APT_MISS_NUM_SHIFT = 1;

  // input synchroniser depth
  localparam int APT_SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    APT_ST_IDLE  = 3'b001,
    APT_ST_LEARN = 3'b010,
    APT_ST_RUN   = 3'b100
  } apt_state_e;

  typedef struct packed {
    logic        enable;
    logic        multi_pulse;
  } apt_ctrl_s;

  typedef struct packed {
    logic        edge_seen;
    logic        missing_seen;
  } apt_edge_s;

endpackage : apt_pkg

/* design/apt_in_sync.sv */
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module apt_in_sync
  import apt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_pulse
);

  logic [2:0] sync_reg;
  logic       level_reg;

  // stage 0 feeds only stage 1; stages 1 and 2 must agree before a change counts
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], async_in};
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
    end
  end

  assign level_out  = level_reg;
  assign rise_pulse = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;

endmodule : apt_in_sync
`default_nettype wire

/* design/apt_angular_timer.sv */
// angular phase timer with axi4-lite register slave
// Functional notes
// (R1) module clock divided by resolution plus one
// (R2) software writes resolution as steps minus one
// (R3) input edge captures period counter value
// (R4) phase clock divides by period value plus one
// (R5) phase event counts, pulses, sets flag
// (R6) one phase pulse per phase increment
// (R7) single-pulse: phase stops at resolution, input clears
// (R8) phase count readable; needs slow phase clock
// (R9) multi-pulse: capture every pulse except after gap
// (R10) pulse after gap: period pulse, flag, phase reset
// (R11) period clock spans gap to gap
// (R12) mode bit selects; gap is interval over 1.5 periods
`timescale 1ns/100ps
`default_nettype none
module apt_angular_timer
  import apt_pkg::*;
#(
  parameter int CNT_W = APT_CNT_W
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        measured_input,
  output logic             phase_clock_out,
  output logic             period_clock_out,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == APT_CTRL_OFS) || (a == APT_RES_OFS) || (a == APT_PER_OFS) ||
                (a == APT_PHS_OFS) || (a == APT_IRQ_OFS) || (a == APT_MASK_OFS) ||
                (a == APT_STAT_OFS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  apt_ctrl_s              ctrl_reg;
  logic [CNT_W-1:0]       resolution_value_reg;
  logic [CNT_W-1:0]       period_value_reg;
  logic [CNT_W-1:0]       period_cnt_reg;
  logic [CNT_W-1:0]       res_div_reg;
  logic [CNT_W-1:0]       phs_div_reg;
  logic [CNT_W-1:0]       phase_count_reg;
  logic [APT_IRQ_W-1:0]   timer_interrupt_flags_0_reg;
  logic [APT_IRQ_W-1:0]   irq_mask_reg;
  logic                   phase_clock_reg;
  logic                   period_clock_reg;
  logic                   after_gap_reg;
  apt_state_e             state_reg;

  logic                   in_level;
  logic                   in_rise;
  logic                   res_tick;
  logic                   phs_tick;
  logic                   gap_now;
  logic                   phase_full;
  logic [CNT_W+1:0]       gap_limit;
  apt_edge_s              edge_ev;

  apt_in_sync u_sync (
    .mclk       (mclk),
    .nrst       (nrst),
    .async_in   (measured_input),
    .level_out  (in_level),
    .rise_pulse (in_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // gap detection and edge classification
  // gap is judged on the running period count so no extra timer is needed
  assign gap_limit = {2'b00, period_value_reg} + ({2'b00, period_value_reg} >> APT_MISS_NUM_SHIFT);
  assign gap_now   = ctrl_reg.multi_pulse && (state_reg == APT_ST_RUN) &&
                     ({2'b00, period_cnt_reg} > gap_limit); // R12
  assign edge_ev.edge_seen    = in_rise && ctrl_reg.enable;
  assign edge_ev.missing_seen = after_gap_reg || gap_now;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= APT_ST_IDLE;
    end else begin
      case (state_reg)
        APT_ST_IDLE:  if (edge_ev.edge_seen) begin
                        state_reg <= APT_ST_LEARN;
                      end
        APT_ST_LEARN: if (edge_ev.edge_seen) begin
                        state_reg <= APT_ST_RUN;
                      end
        APT_ST_RUN:   if (!ctrl_reg.enable) begin
                        state_reg <= APT_ST_IDLE;
                      end
        default:      state_reg <= APT_ST_IDLE;
      endcase
      if (!ctrl_reg.enable) begin
        state_reg <= APT_ST_IDLE;
      end
    end
  end

  // remembers that a gap has been seen until the next input pulse
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      after_gap_reg <= 1'b0;
    end else if (edge_ev.edge_seen || !ctrl_reg.enable || !ctrl_reg.multi_pulse) begin
      after_gap_reg <= 1'b0;
    end else if (gap_now) begin
      after_gap_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resolution divider and period counter
  assign res_tick = ctrl_reg.enable && (res_div_reg == resolution_value_reg); // R1

  always_ff @(posedge mclk) begin
    if (!nrst || !ctrl_reg.enable) begin
      res_div_reg <= '0;
    end else if (edge_ev.edge_seen) begin
      res_div_reg <= '0;
    end else if (res_tick) begin
      res_div_reg <= '0; // R1
    end else begin
      res_div_reg <= res_div_reg + 1'b1;
    end
  end

  // in multi-pulse mode the pulse after a gap restarts the count but is not captured;
  // a count left running would keep the gap test true and mark every later pulse as a gap
  always_ff @(posedge mclk) begin
    if (!nrst || !ctrl_reg.enable) begin
      period_cnt_reg   <= '0;
      period_value_reg <= '0;
    end else if (edge_ev.edge_seen) begin
      if (!(ctrl_reg.multi_pulse && edge_ev.missing_seen)) begin
        period_value_reg <= period_cnt_reg; // R3 R9
      end
      period_cnt_reg <= '0; // R9
    end else if (res_tick && (period_cnt_reg != {CNT_W{1'b1}})) begin
      period_cnt_reg <= period_cnt_reg + 1'b1; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase divider, phase counter and output clocks
  assign phs_tick   = ctrl_reg.enable && (state_reg == APT_ST_RUN) && (phs_div_reg == period_value_reg); // R4
  assign phase_full = !ctrl_reg.multi_pulse && (phase_count_reg == resolution_value_reg);

  logic phase_reset;
  assign phase_reset = edge_ev.edge_seen &&
                       (!ctrl_reg.multi_pulse || edge_ev.missing_seen); // R7 R10 R11

  always_ff @(posedge mclk) begin
    if (!nrst || state_reg != APT_ST_RUN) begin
      phs_div_reg <= '0;
    end else if (phase_reset || phs_tick) begin
      phs_div_reg <= '0; // R4
    end else begin
      phs_div_reg <= phs_div_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || !ctrl_reg.enable) begin
      phase_count_reg <= '0;
    end else if (phase_reset) begin
      phase_count_reg <= '0; // R7 R10
    end else if (phs_tick && !phase_full) begin
      phase_count_reg <= phase_count_reg + 1'b1; // R5 R7
    end
  end

  // one pulse per increment; a held phase counter emits no pulse
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_clock_reg  <= 1'b0;
      period_clock_reg <= 1'b0;
    end else begin
      phase_clock_reg  <= phs_tick && !phase_reset && !phase_full;       // R5 R6
      period_clock_reg <= phase_reset && ctrl_reg.multi_pulse;          // R10 R11
    end
  end

  assign phase_clock_out  = phase_clock_reg;
  assign period_clock_out = period_clock_reg;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: set wins over write-one-to-clear
  logic [APT_IRQ_W-1:0] irq_set;
  logic [APT_IRQ_W-1:0] irq_clr;
  logic                 wr_fire;
  logic [7:0]           aw_addr_reg;
  logic [31:0]          w_data_reg;
  logic                 aw_have_reg;
  logic                 w_have_reg;

  assign irq_set[APT_IRQ_PHS_BIT]  = phs_tick && !phase_reset && !phase_full; // R5
  assign irq_set[APT_IRQ_PER_BIT]  = phase_reset && ctrl_reg.multi_pulse;    // R10
  assign irq_set[APT_IRQ_MISS_BIT] = gap_now && !after_gap_reg;             // R12
  assign irq_clr = (wr_fire && aw_addr_reg == APT_IRQ_OFS) ? w_data_reg[APT_IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timer_interrupt_flags_0_reg <= '0;
    end else begin
      timer_interrupt_flags_0_reg <= (timer_interrupt_flags_0_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(timer_interrupt_flags_0_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_fire       = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte strobes are honoured by the write-lane merge; only low lanes are stored
  logic [31:0] wmask;
  always_comb begin
    wmask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  logic [31:0] wstrb_reg_mask;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wstrb_reg_mask <= 32'h0000_0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wstrb_reg_mask <= wmask;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_reg             <= APT_CTRL_RST;
      resolution_value_reg <= APT_RES_RST[CNT_W-1:0];
      irq_mask_reg         <= '0;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        APT_CTRL_OFS: if (wstrb_reg_mask[0]) begin
                        ctrl_reg.enable      <= w_data_reg[APT_CTRL_EN_BIT];
                        ctrl_reg.multi_pulse <= w_data_reg[APT_CTRL_MULTI_BIT]; // R12
                      end
        APT_RES_OFS:  resolution_value_reg <= (resolution_value_reg & ~wstrb_reg_mask[CNT_W-1:0]) |
                                              (w_data_reg[CNT_W-1:0] & wstrb_reg_mask[CNT_W-1:0]); // R2
        APT_MASK_OFS: if (wstrb_reg_mask[0]) begin
                        irq_mask_reg <= w_data_reg[APT_IRQ_W-1:0];
                      end
        default:      ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel: one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr & 8'hFC)
      APT_CTRL_OFS: rd_mux = {30'h0, ctrl_reg.multi_pulse, ctrl_reg.enable};
      APT_RES_OFS:  rd_mux[CNT_W-1:0] = resolution_value_reg;
      APT_PER_OFS:  rd_mux[CNT_W-1:0] = period_value_reg;
      APT_PHS_OFS:  rd_mux[CNT_W-1:0] = phase_count_reg; // R8
      APT_IRQ_OFS:  rd_mux[APT_IRQ_W-1:0] = timer_interrupt_flags_0_reg;
      APT_MASK_OFS: rd_mux[APT_IRQ_W-1:0] = irq_mask_reg;
      APT_STAT_OFS: rd_mux = {28'h0, after_gap_reg, state_reg};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= is_mapped(s_axi_araddr & 8'hFC) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_gap_pulse;
    edge_ev.edge_seen && ctrl_reg.multi_pulse && edge_ev.missing_seen;
  endsequence

  chk_res_divider: assert property (@(posedge mclk) disable iff (!nrst) // R1
    res_tick |=> (res_div_reg == '0)) else $error("resolution divider did not wrap");
  chk_period_capture: assert property (@(posedge mclk) disable iff (!nrst) // R3
    (edge_ev.edge_seen && !ctrl_reg.multi_pulse) |=> (period_value_reg == $past(period_cnt_reg)))
    else $error("period value not captured");
  chk_phase_div: assert property (@(posedge mclk) disable iff (!nrst) // R4
    (phs_tick && !phase_reset) |=> (phs_div_reg == '0)) else $error("phase divider did not wrap");
  chk_phase_pulse: assert property (@(posedge mclk) disable iff (!nrst) // R6
    phase_clock_out |-> (phase_count_reg == $past(phase_count_reg) + 1'b1))
    else $error("phase pulse without increment");
  chk_phase_flag: assert property (@(posedge mclk) disable iff (!nrst) // R5
    phase_clock_out |-> timer_interrupt_flags_0_reg[APT_IRQ_PHS_BIT]) else $error("phase flag not set");
  chk_phase_limit: assert property (@(posedge mclk) disable iff (!nrst) // R7
    (!ctrl_reg.multi_pulse && ctrl_reg.enable && $stable(resolution_value_reg) &&
     phase_count_reg <= resolution_value_reg) |=> (phase_count_reg <= resolution_value_reg))
    else $error("phase count passed resolution");
  chk_gap_hold: assert property (@(posedge mclk) disable iff (!nrst) // R9
    s_gap_pulse |=> $stable(period_value_reg)) else $error("period captured after gap");
  chk_gap_effects: assert property (@(posedge mclk) disable iff (!nrst) // R10
    s_gap_pulse |=> (period_clock_out && phase_count_reg == '0 &&
                     timer_interrupt_flags_0_reg[APT_IRQ_PER_BIT]))
    else $error("gap pulse effects missing");
  chk_sync_level: assert property (@(posedge mclk) disable iff (!nrst) // R3
    in_rise |=> in_level) else $error("input level not updated after rise");

endmodule : apt_angular_timer
`default_nettype wire

/* tb/apt_sig_model.sv */
// stand-in for the rotation sensor: periodic pulses with an optional missing tooth
`timescale 1ns/100ps
`default_nettype none
module apt_sig_model (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic [15:0] period,
  input  wire logic [3:0]  miss_n,
  output logic             sig
);
  logic [15:0] cnt_reg;
  logic [3:0]  tooth_reg;
  logic        wrap;

  assign wrap = (cnt_reg == period - 16'h0001);

  always_ff @(posedge mclk) begin
    if (!run || wrap) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // a zero tooth count means a full wheel with no gap
  always_ff @(posedge mclk) begin
    if (!run || (wrap && tooth_reg == miss_n - 4'h1)) begin
      tooth_reg <= 4'h0;
    end else if (wrap) begin
      tooth_reg <= tooth_reg + 4'h1;
    end
  end

  // pulses stay several clocks wide so the input filter sees them
  assign sig = run && (cnt_reg < 16'h0004) && !(miss_n != 4'h0 && tooth_reg == miss_n - 4'h1);
endmodule : apt_sig_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the angular phase timer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import apt_pkg::*;
  typedef struct {logic [7:0] a; bit wr; logic [31:0] wd; logic [31:0] rd; logic [1:0] resp;} apt_row_s;
  localparam int P = 210;
  logic        mclk, nrst, sig, pclk, perclk, irq, run;
  logic [3:0]  miss_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  int          err_count, tests_run, phs_cnt, per_cnt, n;
  apt_row_s    rows [8] = '{
    '{APT_CTRL_OFS, 1'b1, 32'h0000_0002, 32'h0000_0002, 2'b00},
    '{APT_RES_OFS, 1'b1, 32'h0001_2345, 32'h0000_2345, 2'b00},
    '{APT_MASK_OFS, 1'b1, 32'h0000_0007, 32'h0000_0007, 2'b00},
    '{APT_PER_OFS, 1'b1, 32'h0000_FFFF, 32'h0000_0000, 2'b00},
    '{APT_PHS_OFS, 1'b1, 32'h0000_FFFF, 32'h0000_0000, 2'b00},
    '{APT_IRQ_OFS, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'b00},
    '{APT_STAT_OFS, 1'b0, 32'h0000_0000, 32'h0000_0001, 2'b00},
    '{8'h1C, 1'b1, 32'h0000_0001, 32'h0000_0000, 2'b10}};

  apt_angular_timer #(.CNT_W(APT_CNT_W)) dut (
    .mclk(mclk), .nrst(nrst), .measured_input(sig), .phase_clock_out(pclk),
    .period_clock_out(perclk), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  apt_sig_model sig_src (.mclk(mclk), .run(run), .period(16'(P)), .miss_n(miss_n), .sig(sig));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (pclk === 1'b1) phs_cnt++;
    if (perclk === 1'b1) per_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic tmo();
    err_count++;
    $display("mismatch wait expected handshake seen none");
    end_of_test();
  endtask : tmo

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // handshakes are judged at the falling edge, where they equal what the next rising edge samples
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw = 1'b0;
    bit w  = 1'b0;
    bit b  = 1'b0;
    int k  = 0;
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b && k < 100) begin
      @(negedge mclk);
      aw = awvalid & awready; w = wvalid & wready; b = bvalid & bready; r = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      k++;
    end
    if (!b) tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar = 1'b0;
    bit rv = 1'b0;
    int k  = 0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rv && k < 100) begin
      @(negedge mclk);
      ar = arvalid & arready; rv = rvalid & rready; d = rdata; r = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
      k++;
    end
    if (!rv) tmo();
  endtask : axi_rd

  task automatic wait_pc(output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (perclk !== 1'b1 && c < 3000);
    if (c >= 3000) tmo();
  endtask : wait_pc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0; run = 1'b0; miss_n = 4'h0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    err_count = 0; tests_run = 0; phs_cnt = 0; per_cnt = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].wd, resp);
      if (rows[i].wr && rows[i].resp != 2'b00) check("bresp", {30'h0, resp}, {30'h0, rows[i].resp});
      axi_rd(rows[i].a, data, resp);
      check("rdata", data, rows[i].rd);
      check("rresp", {30'h0, resp}, {30'h0, rows[i].resp});
    end
    $display("register table test done");
    // single pulse: four steps per turn
    axi_wr(APT_RES_OFS, 32'h0000_0003, resp);
    axi_wr(APT_CTRL_OFS, 32'h0000_0001, resp);
    run <= 1'b1;
    repeat (6 * P) @(posedge mclk);
    axi_rd(APT_PER_OFS, data, resp);
    check("period_value", 32'(data inside {32'h0000_0034, 32'h0000_0035}), 32'h0000_0001);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (sig !== 1'b1 && n < 3000);
    if (n >= 3000) tmo();
    phs_cnt = 0;
    per_cnt = 0;
    repeat (4 * P) @(posedge mclk);
    check("phase pulses", 32'(phs_cnt), 32'h0000_000C);
    check("period pulses", 32'(per_cnt), 32'h0000_0000);
    axi_rd(APT_PHS_OFS, data, resp);
    check("phase_count", 32'(data <= 32'h0000_0003), 32'h0000_0001);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    axi_rd(APT_IRQ_OFS, data, resp);
    check("phase flag", data & 32'h0000_0001, 32'h0000_0001);
    axi_wr(APT_MASK_OFS, 32'h0000_0000, resp);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    axi_wr(APT_CTRL_OFS, 32'h0000_0000, resp);
    axi_wr(APT_MASK_OFS, 32'h0000_0007, resp);
    axi_wr(APT_IRQ_OFS, 32'h0000_0007, resp);
    axi_rd(APT_IRQ_OFS, data, resp);
    check("flags cleared", data, 32'h0000_0000);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    $display("single pulse test done");
    // multi pulse: every fourth tooth missing
    miss_n <= 4'h4;
    axi_wr(APT_CTRL_OFS, 32'h0000_0003, resp);
    repeat (10 * P) @(posedge mclk);
    wait_pc(n);
    wait_pc(n);
    check("gap to gap", 32'(n), 32'h0000_0348);
    axi_rd(APT_IRQ_OFS, data, resp);
    check("period and gap flags", data & 32'h0000_0006, 32'h0000_0006);
    $display("multi pulse test done");
    // reset in mid-run clears control and outputs
    nrst <= 1'b0;
    repeat (5) @(posedge mclk);
    check("irq in reset", {31'h0, irq}, 32'h0000_0000);
    check("phase out in reset", {31'h0, pclk}, 32'h0000_0000);
    nrst <= 1'b1;
    axi_rd(APT_CTRL_OFS, data, resp);
    check("ctrl after reset", data, 32'h0000_0000);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
